// >>> verilog/smf_cfg.svh
// Constants of the sensor fault status and mask group.
// Assumes byte-wide registers reached by an 8-bit register index.
`ifndef SMF_CFG_SVH
`define SMF_CFG_SVH

// Register index of each status and mask byte
`define SMF_OFF_NO_ACK_STATUS    8'hb6
`define SMF_OFF_PKT_CHECK_STATUS 8'hb7
`define SMF_OFF_BUS_STALL_STATUS 8'hb8
`define SMF_OFF_LIMIT_STATUS     8'hb9
`define SMF_OFF_INVALID_STATUS   8'hba
`define SMF_OFF_OVERHEAT_STATUS  8'hbb
`define SMF_OFF_NO_ACK_MASK      8'hbc
`define SMF_OFF_PKT_CHECK_MASK   8'hbd
`define SMF_OFF_BUS_STALL_MASK   8'hbe
`define SMF_OFF_LIMIT_MASK       8'hbf

// Power-on value of every byte in the group
`define SMF_RESET_BYTE 8'h00
// Answer to an unmapped index
`define SMF_UNMAPPED_BYTE 8'h00
// Number of hub invalid-code flags, bits 0 up
`define SMF_INVALID_COUNT 3'h5
// Reserved upper bits of the invalid-code byte
`define SMF_INVALID_RSVD_MASK 8'he0

`endif

// >>> verilog/smf_pkg.sv
// Types and helpers of the sensor fault status and mask group.
// Assumes smf_cfg.svh for the numeric constants.
`default_nettype none
package smf_pkg;
  typedef logic [7:0]        smf_byte_t;
  typedef logic [2:0]        smf_dev_t;
  typedef logic signed [8:0] smf_wide_t;

  // Reading widened so signed and unsigned bytes compare on one scale
  function automatic smf_wide_t smf_widen(input smf_byte_t v,
                                          input logic      is_signed);
    smf_widen = smf_wide_t'({is_signed & v[7], v});
  endfunction

  // Register index match
  function automatic logic smf_hit(input smf_byte_t a, input smf_byte_t o);
    smf_hit = (a == o);
  endfunction
endpackage
`default_nettype wire

// >>> verilog/smf_limit_cmp.sv
// Limit comparator for one temperature reading.
// Assumes the reading and limits are stable in the cycle they are used.
`timescale 1ns/1ps
`default_nettype none
module smf_limit_cmp
(
  input  wire logic             reading_signed_in,
  input  wire smf_pkg::smf_byte_t reading_in,
  input  wire smf_pkg::smf_byte_t high_limit_in,
  input  wire smf_pkg::smf_byte_t low_limit_in,
  input  wire smf_pkg::smf_byte_t overheat_limit_in,
  output logic                  out_of_limits_out,
  output logic                  overheat_out
);
  import smf_pkg::*;

  smf_wide_t reading_w;

  // High and overheat limits unsigned, low limit two's complement
  always_comb
  begin
    reading_w         = smf_widen(reading_in, reading_signed_in);
    out_of_limits_out = (reading_w > smf_widen(high_limit_in, 1'b0)) ||
                        (reading_w < smf_widen(low_limit_in, 1'b1));
    overheat_out      = reading_w > smf_widen(overheat_limit_in, 1'b0);
  end
endmodule // smf_limit_cmp
`default_nettype wire

// >>> verilog/smf_flag_bank.sv
// Eight per-device flags, each holding the outcome of the latest poll.
// Assumes update pulses come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "smf_cfg.svh"
module smf_flag_bank
(
  input  wire logic               mclk_in,
  input  wire logic               arst_n_in,
  input  wire logic               upd_in,
  input  wire smf_pkg::smf_dev_t  idx_in,
  input  wire logic               bit_in,
  output logic [7:0]              flags_out
);
  import smf_pkg::*;

  logic [7:0] next_flags;

  // Only the addressed device's flag moves
  always_comb
  begin
    next_flags = flags_out;
    if (upd_in)
      next_flags[idx_in] = bit_in;
  end

  // Flags start clear at power-up
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      flags_out <= `SMF_RESET_BYTE;                              // [R8]
    else
      flags_out <= next_flags;
  end
endmodule // smf_flag_bank
`default_nettype wire

// >>> verilog/smf_fault_regs.sv
// Status and mask registers of the autonomous sensor poller, plus alert.
// Assumes the two-wire slave engine presents a byte register port and
// the poller reports each poll result as a one-cycle pulse on mclk_in.
//
// Contract
// R1: per-device out-of-limits flag, latest reading
// R2: five hub invalid-code flags, bits 5-7 reserved
// R3: per-device overheat flag above overheat limit
// R4: mask byte gates missing-acknowledge events
// R5: mask byte gates packet-check failure events
// R6: mask byte gates bus timeout events
// R7: mask byte gates limit-violation events
// R8: power-up clears every flag and mask
// R9: read-only no-ack, packet-check, timeout flags
// R10: compare with shared high, low, overheat limits
// R11: masks gate alert only; status writes ignored
`timescale 1ns/1ps
`default_nettype none
`include "smf_cfg.svh"
module smf_fault_regs
(
  input  wire logic               mclk_in,
  input  wire logic               arst_n_in,
  // Register port from the slave engine
  input  wire smf_pkg::smf_byte_t reg_addr_in,
  input  wire logic               reg_wr_in,
  input  wire smf_pkg::smf_byte_t reg_wdata_in,
  input  wire logic               reg_rd_in,
  output logic                    reg_rvalid_out,
  output smf_pkg::smf_byte_t      reg_rdata_out,
  // Poll result from the master
  input  wire logic               result_valid_in,
  input  wire smf_pkg::smf_dev_t  result_dev_in,
  input  wire smf_pkg::smf_byte_t result_temp_in,
  input  wire logic               result_signed_in,
  input  wire logic               missing_ack_in,
  input  wire logic               pkt_check_err_in,
  input  wire logic               bus_stall_err_in,
  // Hub temperature code result
  input  wire logic               hub_valid_in,
  input  wire smf_pkg::smf_dev_t  hub_idx_in,
  input  wire logic               hub_reserved_in,
  // Shared limits
  input  wire smf_pkg::smf_byte_t high_limit_in,
  input  wire smf_pkg::smf_byte_t low_limit_in,
  input  wire smf_pkg::smf_byte_t overheat_limit_in,
  output logic                    alert_out
);
  import smf_pkg::*;

  logic       cmp_lim;
  logic       cmp_hot;
  logic       ok_valid;
  logic       hub_upd;
  logic [7:0] missing_ack_flag;
  logic [7:0] pkt_check_flag;
  logic [7:0] bus_stall_error_flag;
  logic [7:0] limit_violation_flag;
  logic [7:0] overheat_trip_flag;
  logic [7:0] invalid_code_raw;
  logic [7:0] invalid_code_flag;
  smf_byte_t  no_ack_event_mask;
  smf_byte_t  packet_check_event_mask;
  smf_byte_t  bus_stall_event_mask;
  smf_byte_t  limit_event_mask;
  smf_byte_t  next_no_ack_mask;
  smf_byte_t  next_pkt_mask;
  smf_byte_t  next_stall_mask;
  smf_byte_t  next_limit_mask;
  smf_byte_t  next_rdata;
  logic       next_rvalid;
  logic       next_alert;

  // Reading against the shared limits
  smf_limit_cmp u_cmp                                            // [R10]
  (
    .reading_signed_in (result_signed_in),
    .reading_in        (result_temp_in),
    .high_limit_in     (high_limit_in),
    .low_limit_in      (low_limit_in),
    .overheat_limit_in (overheat_limit_in),
    .out_of_limits_out (cmp_lim),
    .overheat_out      (cmp_hot)
  );

  // A poll with no acknowledge carries no reading, so limits stay put
  assign ok_valid = result_valid_in & ~missing_ack_in;
  // Hub only reports five channels; higher indices are dropped
  assign hub_upd  = hub_valid_in & (hub_idx_in < `SMF_INVALID_COUNT); // [R2]

  smf_flag_bank u_nack                                           // [R9]
  (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .upd_in    (result_valid_in),
    .idx_in    (result_dev_in),
    .bit_in    (missing_ack_in),
    .flags_out (missing_ack_flag)
  );

  smf_flag_bank u_pec                                            // [R9]
  (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .upd_in    (result_valid_in),
    .idx_in    (result_dev_in),
    .bit_in    (pkt_check_err_in),
    .flags_out (pkt_check_flag)
  );

  smf_flag_bank u_stall                                          // [R9]
  (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .upd_in    (result_valid_in),
    .idx_in    (result_dev_in),
    .bit_in    (bus_stall_err_in),
    .flags_out (bus_stall_error_flag)
  );

  smf_flag_bank u_lim                                            // [R1]
  (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .upd_in    (ok_valid),
    .idx_in    (result_dev_in),
    .bit_in    (cmp_lim),
    .flags_out (limit_violation_flag)
  );

  smf_flag_bank u_hot                                            // [R3]
  (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .upd_in    (ok_valid),
    .idx_in    (result_dev_in),
    .bit_in    (cmp_hot),
    .flags_out (overheat_trip_flag)
  );

  smf_flag_bank u_inv                                            // [R2]
  (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .upd_in    (hub_upd),
    .idx_in    (hub_idx_in),
    .bit_in    (hub_reserved_in),
    .flags_out (invalid_code_raw)
  );

  // Reserved bits can never be set, forced to zero regardless
  assign invalid_code_flag = invalid_code_raw & ~`SMF_INVALID_RSVD_MASK;

  // Mask writes, read mux and alert; status indices take no write
  always_comb
  begin
    next_no_ack_mask = no_ack_event_mask;
    next_pkt_mask    = packet_check_event_mask;
    next_stall_mask  = bus_stall_event_mask;
    next_limit_mask  = limit_event_mask;
    if (reg_wr_in && smf_hit(reg_addr_in, `SMF_OFF_NO_ACK_MASK))
      next_no_ack_mask = reg_wdata_in;                           // [R4]
    if (reg_wr_in && smf_hit(reg_addr_in, `SMF_OFF_PKT_CHECK_MASK))
      next_pkt_mask = reg_wdata_in;                              // [R5]
    if (reg_wr_in && smf_hit(reg_addr_in, `SMF_OFF_BUS_STALL_MASK))
      next_stall_mask = reg_wdata_in;                            // [R6]
    if (reg_wr_in && smf_hit(reg_addr_in, `SMF_OFF_LIMIT_MASK))
      next_limit_mask = reg_wdata_in;                            // [R7]

    next_rvalid = reg_rd_in;
    next_rdata  = reg_rdata_out;
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        `SMF_OFF_NO_ACK_STATUS:    next_rdata = missing_ack_flag;
        `SMF_OFF_PKT_CHECK_STATUS: next_rdata = pkt_check_flag;
        `SMF_OFF_BUS_STALL_STATUS: next_rdata = bus_stall_error_flag;
        `SMF_OFF_LIMIT_STATUS:     next_rdata = limit_violation_flag;
        `SMF_OFF_INVALID_STATUS:   next_rdata = invalid_code_flag;
        `SMF_OFF_OVERHEAT_STATUS:  next_rdata = overheat_trip_flag;
        `SMF_OFF_NO_ACK_MASK:      next_rdata = no_ack_event_mask;
        `SMF_OFF_PKT_CHECK_MASK:   next_rdata = packet_check_event_mask;
        `SMF_OFF_BUS_STALL_MASK:   next_rdata = bus_stall_event_mask;
        `SMF_OFF_LIMIT_MASK:       next_rdata = limit_event_mask;
        default:                   next_rdata = `SMF_UNMAPPED_BYTE;
      endcase
    end

    // Mask gates the alert only, flags keep tracking underneath
    next_alert = |(missing_ack_flag     & ~no_ack_event_mask)       ||
                 |(pkt_check_flag       & ~packet_check_event_mask) ||
                 |(bus_stall_error_flag & ~bus_stall_event_mask)    ||
                 |((limit_violation_flag | overheat_trip_flag) &
                   ~limit_event_mask);                           // [R11]
  end

  // Everything starts unmasked and quiet
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      no_ack_event_mask       <= `SMF_RESET_BYTE;                // [R8]
      packet_check_event_mask <= `SMF_RESET_BYTE;
      bus_stall_event_mask    <= `SMF_RESET_BYTE;
      limit_event_mask        <= `SMF_RESET_BYTE;
      reg_rdata_out           <= `SMF_RESET_BYTE;
      reg_rvalid_out          <= 1'b0;
      alert_out               <= 1'b0;
    end
    else
    begin
      no_ack_event_mask       <= next_no_ack_mask;
      packet_check_event_mask <= next_pkt_mask;
      bus_stall_event_mask    <= next_stall_mask;
      limit_event_mask        <= next_limit_mask;
      reg_rdata_out           <= next_rdata;
      reg_rvalid_out          <= next_rvalid;
      alert_out               <= next_alert;
    end
  end

  // Helper: high only in the first cycle after reset release
  logic first_cyc;
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      first_cyc <= 1'b1;
    else
      first_cyc <= 1'b0;
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_good_poll;
    result_valid_in && !missing_ack_in;
  endsequence

  sequence s_all_masked;
    (&no_ack_event_mask && &packet_check_event_mask &&
     &bus_stall_event_mask && &limit_event_mask) [*3];
  endsequence

  a_limit_latest: assert property ( // [R1]
    s_good_poll |=>
      limit_violation_flag[$past(result_dev_in)] == $past(cmp_lim))
    else $error("limit flag does not follow latest reading");

  a_invalid_flag: assert property ( // [R2]
    hub_valid_in && hub_idx_in < 3'h5 |=>
      invalid_code_flag[$past(hub_idx_in)] == $past(hub_reserved_in))
    else $error("invalid-code flag not updated");

  a_invalid_rsvd: assert property ( // [R2]
    reg_rd_in && reg_addr_in == 8'hba |=> reg_rdata_out[7:5] == 3'h0)
    else $error("reserved invalid-code bits read nonzero");

  a_overheat_hot: assert property ( // [R3]
    s_good_poll and
    (!result_signed_in && result_temp_in > overheat_limit_in)
    |=> overheat_trip_flag[$past(result_dev_in)])
    else $error("overheat flag missed a hot reading");

  a_nack_mask_wr: assert property ( // [R4]
    reg_wr_in && reg_addr_in == 8'hbc ##1 !reg_wr_in
    ##1 reg_rd_in && reg_addr_in == 8'hbc
    |=> reg_rdata_out == $past(reg_wdata_in, 3))
    else $error("no-ack mask did not take write");

  a_pec_mask_wr: assert property ( // [R5]
    reg_wr_in && reg_addr_in == 8'hbd |=>
      packet_check_event_mask == $past(reg_wdata_in))
    else $error("packet-check mask did not take write");

  a_stall_mask_wr: assert property ( // [R6]
    reg_wr_in && reg_addr_in == 8'hbe |=>
      bus_stall_event_mask == $past(reg_wdata_in))
    else $error("timeout mask did not take write");

  a_limit_mask_gate: assert property ( // [R7]
    (limit_event_mask == 8'hff && !(|missing_ack_flag) &&
     !(|pkt_check_flag) && !(|bus_stall_error_flag)) [*2] |-> !alert_out)
    else $error("masked limit event reached alert");

  a_reset_clear: assert property ( // [R8]
    first_cyc |-> limit_violation_flag == 8'h00 &&
      overheat_trip_flag == 8'h00 && limit_event_mask == 8'h00 &&
      no_ack_event_mask == 8'h00 && !alert_out)
    else $error("group not clear after reset");

  a_nack_alert: assert property ( // [R9]
    result_valid_in && missing_ack_in && !reg_wr_in &&
    !no_ack_event_mask[result_dev_in] |=> ##1 alert_out)
    else $error("unmasked no-ack did not raise alert");

  a_high_compare: assert property ( // [R10]
    s_good_poll and
    (!result_signed_in && result_temp_in > high_limit_in)
    |=> limit_violation_flag[$past(result_dev_in)])
    else $error("reading above high limit not flagged");

  a_all_masked: assert property ( // [R11]
    s_all_masked |-> !alert_out)
    else $error("alert with every source masked");

  a_status_ro: assert property ( // [R11]
    reg_wr_in && reg_addr_in == 8'hb9 && !result_valid_in |=>
      $stable(limit_violation_flag))
    else $error("write changed a status byte");
endmodule // smf_fault_regs
`default_nettype wire

// >>> sim/smf_poll_model.sv
// Behavioural poller and hub feeding poll results to the status group.
// Assumes the bench calls its tasks; it drives on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module smf_poll_model
(
  input  wire logic  mclk_in,
  output logic       result_valid_out,
  output logic [2:0] result_dev_out,
  output logic [7:0] result_temp_out,
  output logic       result_signed_out,
  output logic [2:0] err_out,
  output logic       hub_valid_out,
  output logic [2:0] hub_idx_out,
  output logic       hub_reserved_out
);
  // Quiet bus at time zero
  initial
  begin
    {result_valid_out, result_dev_out, result_temp_out} = '0;
    {result_signed_out, err_out} = '0;
    {hub_valid_out, hub_idx_out, hub_reserved_out} = '0;
  end

  // One poll, one cycle; qualifiers inverted afterwards so late
  // sampling sees garbage rather than a stale match
  task automatic poll(input logic [2:0] dev, input logic [7:0] temp,
                      input logic sgn, input logic [2:0] err);
    @(negedge mclk_in);
    {result_dev_out, result_temp_out, result_signed_out} = {dev, temp, sgn};
    err_out = err; // No-ack, packet check, stall
    result_valid_out = 1'b1;
    @(negedge mclk_in);
    result_valid_out = 1'b0;
    {result_dev_out, result_temp_out} = ~{dev, temp};
    {result_signed_out, err_out} = ~{sgn, err};
  endtask

  // One hub code result
  task automatic hub(input logic [2:0] idx, input logic rsv);
    @(negedge mclk_in);
    {hub_idx_out, hub_reserved_out} = {idx, rsv};
    hub_valid_out = 1'b1;
    @(negedge mclk_in);
    hub_valid_out = 1'b0;
    {hub_idx_out, hub_reserved_out} = ~{idx, rsv};
  endtask
endmodule // smf_poll_model
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench of the sensor fault status and mask group.
// Assumes smf_poll_model stands in for the poller and the hub.
`timescale 1ns/1ps
`default_nettype none
`include "smf_cfg.svh"
module tb_top;
  import smf_pkg::*;
  logic       mclk_in, arst_n_in, reg_wr, reg_rd, rvalid, alert;
  logic       res_v, res_s, hub_v, hub_r;
  logic [2:0] res_err, res_dev, hub_i;
  smf_byte_t  reg_addr, reg_wdata, rdata, res_t;
  int         mismatches, n_tests;
  int         cyc = 0;
  // Readings of devices 0..7 against high 0x50, low -10, overheat 0x64
  smf_byte_t  temps [8] = '{8'h60, 8'h70, 8'h50, 8'hf0,
                            8'hf6, 8'h64, 8'hf0, 8'h20};
  logic [7:0] sgn = 8'h18;

  smf_fault_regs dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata),
    .reg_rd_in(reg_rd), .reg_rvalid_out(rvalid), .reg_rdata_out(rdata),
    .result_valid_in(res_v), .result_dev_in(res_dev),
    .result_temp_in(res_t), .result_signed_in(res_s),
    .missing_ack_in(res_err[2]), .pkt_check_err_in(res_err[1]),
    .bus_stall_err_in(res_err[0]), .hub_valid_in(hub_v),
    .hub_idx_in(hub_i), .hub_reserved_in(hub_r), .high_limit_in(8'h50),
    .low_limit_in(8'hf6), .overheat_limit_in(8'h64), .alert_out(alert));

  smf_poll_model u_poll (.mclk_in(mclk_in), .result_valid_out(res_v),
    .result_dev_out(res_dev), .result_temp_out(res_t),
    .result_signed_out(res_s), .err_out(res_err), .hub_valid_out(hub_v),
    .hub_idx_out(hub_i), .hub_reserved_out(hub_r));

  // Free-running clock
  initial
  begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  // Hang guard, far above the 190 or so cycles the tests need
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      mismatches++;
      $display("MISMATCH t=%0t run timed out", $time);
      results();
    end
  end

  task automatic check8(input smf_byte_t got, input smf_byte_t exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic wr(input smf_byte_t a, input smf_byte_t d);
    @(negedge mclk_in);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk_in);
    reg_wr = 1'b0;
  endtask

  // Valid stands for the one cycle after the taking edge; read data holds until the next read
  task automatic rd_chk(input smf_byte_t a, input smf_byte_t exp);
    @(negedge mclk_in);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk_in);
    reg_rd = 1'b0;
    check1(rvalid, 1'b1);
    check8(rdata, exp);
  endtask

  // Alert is registered behind the flags and masks
  task automatic alert_chk(input logic exp);
    repeat (2) @(negedge mclk_in);
    check1(alert, exp);
  endtask

  // Whole group plus one unmapped index all read zero
  task automatic all_zero;
    for (int a = 'hb6; a <= 'hc0; a++)
      rd_chk(smf_byte_t'(a), 8'h00);
  endtask

  task automatic results;
    $display("counts: %0d comparisons, %0d mismatches", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {mismatches, n_tests} = '0;
    arst_n_in = 1'b0;
    repeat (6) @(posedge mclk_in);
    @(negedge mclk_in);
    arst_n_in = 1'b1;
    check1(alert, 1'b0);
    all_zero();
    $display("test reset done");
    // Mask bytes hold what is written; status bytes ignore writes
    for (int i = 0; i < 4; i++)
      wr(smf_byte_t'(8'hbc + i), smf_byte_t'(8'h5a ^ i));
    for (int i = 0; i < 4; i++)
      rd_chk(smf_byte_t'(8'hbc + i), smf_byte_t'(8'h5a ^ i));
    wr(`SMF_OFF_LIMIT_STATUS, 8'hff);
    wr(`SMF_OFF_INVALID_STATUS, 8'hff);
    rd_chk(`SMF_OFF_LIMIT_STATUS, 8'h00);
    rd_chk(`SMF_OFF_INVALID_STATUS, 8'h00);
    for (int i = 0; i < 4; i++)
      wr(smf_byte_t'(8'hbc + i), 8'h00);
    $display("test access done");
    // Limit comparisons, equal values stay inside
    for (int d = 0; d < 8; d++)
      u_poll.poll(smf_dev_t'(d), temps[d], sgn[d], 3'b000);
    rd_chk(`SMF_OFF_LIMIT_STATUS, 8'h6b);
    rd_chk(`SMF_OFF_OVERHEAT_STATUS, 8'h42);
    alert_chk(1'b1);
    wr(`SMF_OFF_LIMIT_MASK, 8'h6b);
    alert_chk(1'b0);
    rd_chk(`SMF_OFF_LIMIT_STATUS, 8'h6b);
    wr(`SMF_OFF_LIMIT_MASK, 8'h2b);
    alert_chk(1'b1);
    wr(`SMF_OFF_LIMIT_MASK, 8'hff);
    alert_chk(1'b0);
    $display("test limits done");
    // Error events, each unmasked then masked per device
    u_poll.poll(3'd0, 8'h10, 1'b0, 3'b100);
    rd_chk(`SMF_OFF_LIMIT_STATUS, 8'h6b);
    rd_chk(`SMF_OFF_NO_ACK_STATUS, 8'h01);
    alert_chk(1'b1);
    wr(`SMF_OFF_NO_ACK_MASK, 8'h01);
    rd_chk(`SMF_OFF_NO_ACK_MASK, 8'h01);
    alert_chk(1'b0);
    u_poll.poll(3'd5, 8'h20, 1'b0, 3'b010);
    rd_chk(`SMF_OFF_PKT_CHECK_STATUS, 8'h20);
    alert_chk(1'b1);
    wr(`SMF_OFF_PKT_CHECK_MASK, 8'h20);
    alert_chk(1'b0);
    u_poll.poll(3'd6, 8'h20, 1'b0, 3'b001);
    rd_chk(`SMF_OFF_BUS_STALL_STATUS, 8'h40);
    rd_chk(`SMF_OFF_LIMIT_STATUS, 8'h0b);
    rd_chk(`SMF_OFF_OVERHEAT_STATUS, 8'h02);
    rd_chk(`SMF_OFF_NO_ACK_STATUS, 8'h01);
    alert_chk(1'b1);
    wr(`SMF_OFF_BUS_STALL_MASK, 8'h40);
    alert_chk(1'b0);
    // Every source masked while flags stay set underneath
    for (int i = 0; i < 3; i++)
      wr(smf_byte_t'(8'hbc + i), 8'hff);
    alert_chk(1'b0);
    $display("test errors done");
    // Hub codes, channels 5..7 not stored, reserved bits read zero
    for (int i = 0; i < 8; i++)
      u_poll.hub(3'(i), 1'b1);
    rd_chk(`SMF_OFF_INVALID_STATUS, 8'h1f);
    u_poll.hub(3'd2, 1'b0);
    rd_chk(`SMF_OFF_INVALID_STATUS, 8'h1b);
    $display("test hub done");
    // Reset in mid-run clears flags and masks again
    arst_n_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    arst_n_in = 1'b1;
    all_zero();
    $display("test second reset done");
    results();
  end
endmodule // tb_top
`default_nettype wire
